/* src/crd_pkg.sv */
// Package of constants and carriers for the cache RAM debug readout block
package crd_pkg;

  // ==========================================================
  // Index operation field layout
  localparam int unsigned IDX_SEL_LSB = 24;
  localparam int unsigned IDX_WAY_LSB = 18;
  localparam int unsigned IDX_WAY_W = 4;
  localparam int unsigned IDX_FIELD_W = 18;
  localparam int unsigned IDX_CORE_LSB = 16;

  // ==========================================================
  // Array selector codes
  localparam logic [7:0] SEL_IPRED = 8'h05;
  localparam logic [7:0] SEL_DTAG = 8'h08;
  localparam logic [7:0] SEL_DDATA = 8'h09;
  localparam logic [7:0] SEL_DLTLB = 8'h0A;
  localparam logic [7:0] SEL_DSTLB = 8'h0B;
  localparam logic [7:0] SEL_L2TAG = 8'h10;
  localparam logic [7:0] SEL_L2DATA = 8'h11;
  localparam logic [7:0] SEL_SNOOP = 8'h12;
  localparam logic [7:0] SEL_L2ECC = 8'h13;
  localparam logic [7:0] SEL_L2DIRTY = 8'h14;
  localparam logic [7:0] SEL_L2TLB = 8'h18;
  localparam logic [7:0] SEL_DSIDE_MIN = 8'h08;

  // ==========================================================
  // Returned field widths, in bits per holding word
  localparam int unsigned W_FULL = 32;
  localparam int unsigned W_L1TAG = 29;
  localparam int unsigned W_L2TAG = 30;
  localparam int unsigned W_ECC7 = 7;
  localparam int unsigned W_TLB_TOP = 6;
  localparam int unsigned W_L2TLB_TOP = 4;
  localparam int unsigned W_DECC = 16;
  localparam int unsigned W_DIRTY = 18;

  // ==========================================================
  // Coprocessor register identifiers
  localparam logic [3:0] REG_INDEX_OP = 4'h0;
  localparam logic [3:0] REG_IHOLD0 = 4'h1;
  localparam logic [3:0] REG_IHOLD1 = 4'h2;
  localparam logic [3:0] REG_IHOLD2 = 4'h3;
  localparam logic [3:0] REG_DHOLD0 = 4'h4;
  localparam logic [3:0] REG_DHOLD1 = 4'h5;
  localparam logic [3:0] REG_DHOLD2 = 4'h6;
  localparam logic [3:0] REG_DHOLD3 = 4'h7;
  localparam logic [3:0] REG_L2AUX = 4'h8;

  // ==========================================================
  // Auxiliary settings register
  localparam int unsigned AUX_NS_RD_DIS_BIT = 10;
  localparam logic AUX_NS_RD_DIS_RST = 1'b0;
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic [3:0] reg_id;
    logic [31:0] wdata;
    logic secure;
    logic priv;
  } crd_cp_req_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [3:0] way;
    logic [9:0] row;
    logic [1:0] bank;
    logic [1:0] dbank;
    logic half;
    logic [1:0] core;
  } crd_arr_req_t;

  typedef struct packed {
    logic [127:0] data;
    logic entry_valid;
    logic entry_secure;
  } crd_arr_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } crd_state_t;

endpackage

/* src/crd_readout.sv */
// Cache, predictor and translation RAM debug readout with holding registers
//
// Contract
// R1: Decode selector, way and index fields.
// R2: Non-secure reads zero invalid or Secure entries.
// R3: Private arrays read by owning core only.
// R4: Predictor: low eight bits, word0, zeros.
// R5: L1 data tag way, row, bank select.
// R6: L1 tag: 29 tag, 7 check bits.
// R7: L1 data set, bank, doubleword select.
// R8: L1 data words and check codes returned.
// R9: Load translation entry, 102 bits, four words.
// R10: Store translation entry, 102 bits, four words.
// R11: L2 tag way, row, bank select.
// R12: L2 tag: 30 tag, 7 check bits.
// R13: L2 data bank select, 128 bits returned.
// R14: Snoop tag uses core select field.
// R15: L2 check-code read gives 16 bits.
// R16: L2 dirty read gives 18 bits.
// R17: L2 translation: way plus 128-entry number.
// R18: Software barriers before reading holding words.
// R19: Auxiliary register writable from Secure only.
// R20: Bit 10 blocks Non-secure debug reads.
// R21: Auxiliary register written only when idle.
// R22: Later changes need translation off, idle.
// R23: Holding words keep values until next op.
`timescale 1ns/100ps

module crd_readout
  import crd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Identity of this core
  input wire logic [1:0] core_id,
  // Coprocessor register access
  input wire logic cp_req,
  input wire crd_cp_req_t cp_cmd,
  output logic cp_ready_q,
  output logic cp_ack_q,
  output logic [31:0] cp_rdata_q,
  // Array read port
  output logic arr_req_q,
  output crd_arr_req_t arr_addr_q,
  input wire logic arr_ack,
  input wire crd_arr_rsp_t arr_rsp,
  // Auxiliary control out to the L2 system
  output logic ns_debug_read_dis_q
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lane(input int unsigned w);
    logic [63:0] m;
    m = (64'h1 << w) - 64'h1;
    return m[31:0];
  endfunction

  // Per-selector mask of valid returned bits, lane 0 lowest
  function automatic logic [127:0] sel_mask(input logic [7:0] sel);
    logic [127:0] m;
    m = '0;
    unique case (sel)
      SEL_IPRED: m = {96'h0, lane(W_FULL)}; // R4
      SEL_DTAG, SEL_SNOOP:
        m = {64'h0, lane(W_ECC7), lane(W_L1TAG)}; // R6 R14
      SEL_DDATA:
        m = {lane(W_ECC7), lane(W_ECC7), lane(W_FULL), lane(W_FULL)}; // R8
      SEL_DLTLB, SEL_DSTLB:
        m = {lane(W_TLB_TOP), {3{lane(W_FULL)}}}; // R9 R10
      SEL_L2TAG: m = {64'h0, lane(W_ECC7), lane(W_L2TAG)}; // R12
      SEL_L2DATA: m = {4{lane(W_FULL)}}; // R13
      SEL_L2ECC: m = {96'h0, lane(W_DECC)}; // R15
      SEL_L2DIRTY: m = {96'h0, lane(W_DIRTY)}; // R16
      SEL_L2TLB: m = {lane(W_L2TLB_TOP), {3{lane(W_FULL)}}}; // R17
      default: m = '0;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Index decode
  logic [7:0] op_sel;
  logic [3:0] op_way;
  logic [IDX_FIELD_W-1:0] op_idx;
  crd_arr_req_t op_addr;
  logic op_known;
  logic op_local;

  always_comb begin
    op_sel = cp_cmd.wdata[IDX_SEL_LSB +: 8]; // R1
    op_way = cp_cmd.wdata[IDX_WAY_LSB +: IDX_WAY_W]; // R1
    op_idx = cp_cmd.wdata[IDX_FIELD_W-1:0]; // R1
    op_addr = '0;
    op_addr.sel = op_sel;
    op_addr.way = op_way;
    op_addr.core = core_id;
    op_known = 1'b1;
    op_local = 1'b1;
    unique case (op_sel)
      SEL_IPRED: op_addr.row = {2'b00, op_idx[7:0]}; // R4
      SEL_DTAG: begin
        op_addr.row = {4'h0, op_idx[13:8]}; // R5
        op_addr.bank = op_idx[7:6]; // R5
      end
      SEL_DDATA: begin
        op_addr.row = {2'b00, op_idx[13:6]}; // R7
        op_addr.dbank = op_idx[5:4]; // R7
        op_addr.half = op_idx[3]; // R7
      end
      SEL_DLTLB, SEL_DSTLB:
        op_addr.row = {5'h00, op_idx[4:0]}; // R9 R10
      SEL_L2TAG, SEL_L2DIRTY: begin
        op_addr.row = op_idx[17:8]; // R11 R16
        op_addr.bank = op_idx[7:6]; // R11 R16
        op_local = 1'b0; // R3
      end
      SEL_L2DATA, SEL_L2ECC: begin
        op_addr.row = op_idx[17:8]; // R13 R15
        op_addr.bank = op_idx[7:6]; // R13 R15
        op_addr.dbank = op_idx[5:4]; // R13 R15
        op_local = 1'b0; // R3
      end
      SEL_SNOOP: begin
        op_addr.core = op_idx[IDX_CORE_LSB +: 2]; // R14
        op_addr.row = {4'h0, op_idx[13:8]}; // R14
        op_addr.bank = op_idx[7:6]; // R14
      end
      SEL_L2TLB: op_addr.row = {3'b000, op_idx[6:0]}; // R17
      default: op_known = 1'b0;
    endcase
    // Private arrays answer only the core that owns them
    if (op_local && (op_addr.core != core_id)) begin
      op_known = 1'b0; // R3
    end
  end

  // ==========================================================
  // State
  crd_state_t st_q, st_d;
  logic [31:0] ihold_q [3];
  logic [31:0] ihold_d [3];
  logic [31:0] dhold_q [4];
  logic [31:0] dhold_d [4];
  logic aux_q, aux_d;
  logic arr_req_d;
  crd_arr_req_t arr_addr_d;
  logic cp_ready_d, cp_ack_d;
  logic [31:0] cp_rdata_d;
  logic pend_ns_q, pend_ns_d;
  logic pend_dside_q, pend_dside_d;
  logic [127:0] pend_mask_q, pend_mask_d;

  logic take;
  logic [127:0] ret;
  logic [31:0] rd_mux;

  assign take = cp_req && cp_ready_q;

  // Register read view
  always_comb begin
    rd_mux = '0;
    unique case (cp_cmd.reg_id)
      REG_IHOLD0: rd_mux = ihold_q[0];
      REG_IHOLD1: rd_mux = ihold_q[1];
      REG_IHOLD2: rd_mux = ihold_q[2];
      REG_DHOLD0: rd_mux = dhold_q[0];
      REG_DHOLD1: rd_mux = dhold_q[1];
      REG_DHOLD2: rd_mux = dhold_q[2];
      REG_DHOLD3: rd_mux = dhold_q[3];
      REG_L2AUX: rd_mux[AUX_NS_RD_DIS_BIT] = aux_q;
      default: rd_mux = '0;
    endcase
  end

  // Masked response, zeroed for hidden entries
  always_comb begin
    ret = arr_rsp.data & pend_mask_q;
    if (pend_ns_q && (!arr_rsp.entry_valid || arr_rsp.entry_secure)) begin
      ret = '0; // R2
    end
  end

  always_comb begin
    st_d = st_q;
    ihold_d = ihold_q; // R23
    dhold_d = dhold_q; // R23
    aux_d = aux_q;
    arr_req_d = arr_req_q;
    arr_addr_d = arr_addr_q;
    cp_ready_d = cp_ready_q;
    cp_ack_d = 1'b0;
    cp_rdata_d = cp_rdata_q;
    pend_ns_d = pend_ns_q;
    pend_dside_d = pend_dside_q;
    pend_mask_d = pend_mask_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take) begin
          cp_rdata_d = '0;
          if (!cp_cmd.priv) begin
            cp_ack_d = 1'b1;
          end else if (!cp_cmd.wr) begin
            cp_rdata_d = rd_mux;
            cp_ack_d = 1'b1;
          end else if (cp_cmd.reg_id == REG_INDEX_OP) begin
            pend_ns_d = !cp_cmd.secure;
            pend_dside_d = (op_sel >= SEL_DSIDE_MIN);
            pend_mask_d = sel_mask(op_sel);
            if (!op_known || (!cp_cmd.secure && aux_q)) begin
              // Nothing to fetch: load zeros straight away
              if (op_sel >= SEL_DSIDE_MIN) begin
                dhold_d = '{default: HOLD_RST}; // R20
              end else begin
                ihold_d = '{default: HOLD_RST}; // R20
              end
              cp_ack_d = 1'b1;
            end else begin
              arr_req_d = 1'b1;
              arr_addr_d = op_addr;
              cp_ready_d = 1'b0;
              st_d = ST_WAIT;
            end
          end else begin
            cp_ack_d = 1'b1;
            unique case (cp_cmd.reg_id)
              REG_IHOLD0: ihold_d[0] = cp_cmd.wdata;
              REG_IHOLD1: ihold_d[1] = cp_cmd.wdata;
              REG_IHOLD2: ihold_d[2] = cp_cmd.wdata;
              REG_DHOLD0: dhold_d[0] = cp_cmd.wdata;
              REG_DHOLD1: dhold_d[1] = cp_cmd.wdata;
              REG_DHOLD2: dhold_d[2] = cp_cmd.wdata;
              REG_DHOLD3: dhold_d[3] = cp_cmd.wdata;
              REG_L2AUX: begin
                if (cp_cmd.secure) begin
                  aux_d = cp_cmd.wdata[AUX_NS_RD_DIS_BIT]; // R19 R20
                end
              end
              default: ;
            endcase
          end
        end
      end
      ST_WAIT: begin
        if (arr_ack) begin
          arr_req_d = 1'b0;
          if (pend_dside_q) begin
            for (int i = 0; i < 4; i++) begin
              dhold_d[i] = ret[32*i +: 32]; // R8 R13
            end
          end else begin
            for (int i = 0; i < 3; i++) begin
              ihold_d[i] = ret[32*i +: 32]; // R4
            end
          end
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        cp_ack_d = 1'b1;
        cp_ready_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
        arr_req_d = 1'b0;
        cp_ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      ihold_q <= '{default: HOLD_RST};
      dhold_q <= '{default: HOLD_RST};
      aux_q <= AUX_NS_RD_DIS_RST;
      arr_req_q <= 1'b0;
      arr_addr_q <= '0;
      cp_ready_q <= 1'b1;
      cp_ack_q <= 1'b0;
      cp_rdata_q <= '0;
      pend_ns_q <= 1'b0;
      pend_dside_q <= 1'b0;
      pend_mask_q <= '0;
      ns_debug_read_dis_q <= AUX_NS_RD_DIS_RST;
    end else if (clk_en) begin
      st_q <= st_d;
      ihold_q <= ihold_d;
      dhold_q <= dhold_d;
      aux_q <= aux_d;
      arr_req_q <= arr_req_d;
      arr_addr_q <= arr_addr_d;
      cp_ready_q <= cp_ready_d;
      cp_ack_q <= cp_ack_d;
      cp_rdata_q <= cp_rdata_d;
      pend_ns_q <= pend_ns_d;
      pend_dside_q <= pend_dside_d;
      pend_mask_q <= pend_mask_d;
      ns_debug_read_dis_q <= aux_d;
    end
  end

endmodule

/* dv/crd_readout_checker.sv */
// Assertion checker for the cache RAM debug readout block
`timescale 1ns/100ps
module crd_readout_checker
  import crd_pkg::*;
(
  // Clock, reset and core identity
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [1:0] core_id,
  // Register access
  input wire logic cp_req,
  input wire crd_cp_req_t cp_cmd,
  input wire logic cp_ready_q,
  input wire logic cp_ack_q,
  input wire logic [31:0] cp_rdata_q,
  // Array port and auxiliary pin
  input wire logic arr_req_q,
  input wire crd_arr_req_t arr_addr_q,
  input wire logic arr_ack,
  input wire crd_arr_rsp_t arr_rsp,
  input wire logic ns_debug_read_dis_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire tk = clk_en && cp_req && cp_ready_q;
  wire op = tk && cp_cmd.wr && cp_cmd.reg_id == REG_INDEX_OP;
  wire aux = tk && cp_cmd.wr && cp_cmd.priv && cp_cmd.reg_id == REG_L2AUX;
  // ==========================================================
  // Completion shapes
  sequence s_finish;
    !arr_req_q ##1 cp_ack_q;
  endsequence
  sequence s_zero_fill;
    cp_ack_q && !arr_req_q;
  endsequence
  // ==========================================================
  // Properties
  AST_READ: assert property (tk && !cp_cmd.wr |=> cp_ack_q)
    else $error("read not answered next cycle");
  AST_LAUNCH: assert property ($rose(arr_req_q) |-> $past(op) &&
    arr_addr_q.way == $past(cp_cmd.wdata[21:18]) &&
    arr_addr_q.sel == $past(cp_cmd.wdata[31:24]))
    else $error("array read launched with wrong fields");
  AST_ADDR: assert property (arr_req_q && $past(arr_req_q) |->
    $stable(arr_addr_q)) else $error("array address moved");
  AST_FINISH: assert property (arr_req_q && arr_ack |=> s_finish)
    else $error("array answer not completed");
  AST_BUSY: assert property (arr_req_q |-> !cp_ready_q)
    else $error("ready while array read pending");
  AST_L2ROW: assert property ($rose(arr_req_q) &&
    arr_addr_q.sel == SEL_L2TAG |-> arr_addr_q.bank ==
    $past(cp_cmd.wdata[7:6]) && arr_addr_q.row == $past(cp_cmd.wdata[17:8]))
    else $error("L2 tag row or bank wrong");
  AST_AUX_SET: assert property (aux && cp_cmd.secure |=>
    ns_debug_read_dis_q == $past(cp_cmd.wdata[10]))
    else $error("aux pin not updated");
  AST_AUX_NS: assert property (aux && !cp_cmd.secure |=>
    $stable(ns_debug_read_dis_q)) else $error("aux changed from ns");
  AST_NS_BLOCK: assert property (op && !cp_cmd.secure &&
    ns_debug_read_dis_q |=> s_zero_fill)
    else $error("blocked read reached array");
  AST_SNOOP: assert property (op && cp_cmd.wdata[31:24] == SEL_SNOOP &&
    cp_cmd.wdata[17:16] != core_id |=> s_zero_fill)
    else $error("foreign snoop read reached array");
  AST_HOLD: assert property (!tk ##1 !cp_ack_q |-> $stable(cp_rdata_q))
    else $error("read data moved");
endmodule
bind crd_readout crd_readout_checker chk (.ref_clk, .nrst, .clk_en,
  .core_id, .cp_req, .cp_cmd, .cp_ready_q, .cp_ack_q, .cp_rdata_q,
  .arr_req_q, .arr_addr_q, .arr_ack, .arr_rsp, .ns_debug_read_dis_q);

/* dv/crd_readout_test.sv */
// Self-checking bench for the cache RAM debug readout block
`timescale 1ns/100ps
module crd_readout_test;
  import crd_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic cp_req = 1'h0;
  logic arr_ack = 1'h0;
  logic [1:0] core_id = 2'h2;
  crd_cp_req_t cmd = '0;
  crd_arr_rsp_t rsp = '0;
  crd_arr_req_t arr_addr_q, seen;
  logic cp_ready_q, cp_ack_q, arr_req_q, ns_debug_read_dis_q;
  logic [31:0] cp_rdata_q, rd, w;
  logic [7:0] sel;
  logic [9:0] erow;
  logic [6:0] fld;
  logic clk_en = 1'h1;
  logic [127:0] pat = {32'hDEAD_BEEF, 32'hCAFE_F00D, 32'hBADC_0FFE,
    32'hFFFF_FFFF};
  int bad_count = 0;
  int n_tests = 0;
  // Selector, row, {bank, dbank, half, core}, widths of words 0 to 3
  logic [56:0] rows [11] = '{
    {8'h05, 10'h0BF, 7'h02, 32'h2000_0000},
    {8'h08, 10'h025, 7'h42, 32'h1D07_0000},
    {8'h09, 10'h096, 7'h1E, 32'h2020_0707},
    {8'h0A, 10'h01F, 7'h02, 32'h2020_2006},
    {8'h0B, 10'h01F, 7'h02, 32'h2020_2006},
    {8'h10, 10'h2A5, 7'h42, 32'h1E07_0000},
    {8'h11, 10'h2A5, 7'h5A, 32'h2020_2020},
    {8'h12, 10'h025, 7'h42, 32'h1D07_0000},
    {8'h13, 10'h2A5, 7'h5A, 32'h1000_0000},
    {8'h14, 10'h2A5, 7'h42, 32'h1200_0000},
    {8'h18, 10'h03F, 7'h02, 32'h2020_2004}};
  always #2.5 ref_clk = ~ref_clk;
  crd_readout uut (.ref_clk, .nrst, .clk_en, .core_id, .cp_req,
    .cp_cmd(cmd), .cp_ready_q, .cp_ack_q, .cp_rdata_q, .arr_req_q,
    .arr_addr_q, .arr_ack, .arr_rsp(rsp), .ns_debug_read_dis_q);
  // ==========================================================
  // Tasks
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] msk(input logic [7:0] n);
    return n >= 8'h20 ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
  endfunction
  // One access; any array read it launches is answered at once
  task automatic cp(input logic wr, s, p, input logic [3:0] id,
    input logic [31:0] d);
    int i;
    @(negedge ref_clk);
    cmd = '{wr, id, d, s, p};
    cp_req = 1'h1;
    @(negedge ref_clk);
    cp_req = 1'h0;
    for (i = 0; i < 20 && cp_ack_q !== 1'h1; i++) begin
      if (arr_req_q === 1'h1) seen = arr_addr_q;
      arr_ack = arr_req_q;
      @(negedge ref_clk);
      arr_ack = 1'h0;
    end
    if (i == 20) begin
      chk("ack timeout", 32'h1, {31'h0, cp_ack_q});
      print_verdict();
    end
    rd = cp_rdata_q;
  endtask
  task automatic idx(input logic s, input logic [31:0] d);
    cp(1'h1, s, 1'h1, REG_INDEX_OP, d);
  endtask
  task automatic rdw(input logic [3:0] id, input logic [31:0] e,
    input string nm);
    cp(1'h0, 1'h1, 1'h1, id, 32'h0);
    chk(nm, e, rd);
  endtask
  // ==========================================================
  // Sequence
  initial begin
    rsp = '{pat, 1'h1, 1'h0};
    repeat (8) @(negedge ref_clk);
    chk("reset ready", 32'h1, {31'h0, cp_ready_q});
    chk("reset pin", 32'h0, {31'h0, ns_debug_read_dis_q});
    nrst = 1'h1;
    rdw(REG_DHOLD0, 32'h0, "reset word");
    foreach (rows[r]) begin
      {sel, erow, fld, w} = rows[r];
      idx(1'h1, {sel, 6'h09, 18'h2A5BF});
      chk("row", {22'h0, erow}, {22'h0, seen.row});
      chk("way", 32'h9, {28'h0, seen.way});
      chk("fields", {25'h0, fld}, {25'h0, seen[6:0]});
      for (int k = 0; k < 4; k++)
        if (sel >= SEL_DSIDE_MIN || k < 3)
          rdw(sel < SEL_DSIDE_MIN ? 4'(REG_IHOLD0 + k) : 4'(REG_DHOLD0 + k),
            pat[32*k +: 32] & msk(w[31-8*k -: 8]), "word");
    end
    idx(1'h1, {8'h01, 24'h0});
    rdw(REG_IHOLD0, 32'h0, "unknown sel");
    for (int k = 0; k < 4; k++) begin
      rsp = '{pat, k != 3, k == 1};
      idx(1'h0, {SEL_L2DATA, 24'h0});
      rdw(REG_DHOLD0, k[0] ? 32'h0 : 32'hFFFF_FFFF, "ns word");
    end
    rsp = '{pat, 1'h1, 1'h0};
    idx(1'h1, {SEL_L2DATA, 24'h0});
    idx(1'h1, {SEL_SNOOP, 24'h01_0000});
    rdw(REG_DHOLD0, 32'h0, "snoop word");
    cp(1'h1, 1'h0, 1'h1, REG_L2AUX, 32'hFFFF_FFFF);
    rdw(REG_L2AUX, 32'h0, "ns aux");
    cp(1'h1, 1'h1, 1'h1, REG_L2AUX, 32'hFFFF_FFFF);
    rdw(REG_L2AUX, 32'h400, "aux");
    chk("aux pin", 32'h1, {31'h0, ns_debug_read_dis_q});
    // A request offered while the clock enable is low is never taken
    @(negedge ref_clk);
    clk_en = 1'h0;
    cmd = '{1'h1, REG_L2AUX, 32'h0, 1'h1, 1'h1};
    cp_req = 1'h1;
    repeat (2) @(negedge ref_clk);
    cp_req = 1'h0;
    clk_en = 1'h1;
    chk("frozen ack", 32'h0, {31'h0, cp_ack_q});
    chk("frozen pin", 32'h1, {31'h0, ns_debug_read_dis_q});
    idx(1'h1, {SEL_L2DATA, 24'h0});
    rdw(REG_DHOLD0, 32'hFFFF_FFFF, "secure word");
    idx(1'h0, {SEL_L2DATA, 24'h0});
    rdw(REG_DHOLD0, 32'h0, "blocked word");
    cp(1'h1, 1'h1, 1'h1, REG_L2AUX, 32'h0);
    cp(1'h1, 1'h1, 1'h1, REG_DHOLD2, 32'hA5A5_A5A5);
    cp(1'h1, 1'h1, 1'h0, REG_DHOLD2, 32'h0);
    cp(1'h0, 1'h1, 1'h0, REG_DHOLD2, 32'h0);
    chk("user read", 32'h0, rd);
    rdw(REG_DHOLD2, 32'hA5A5_A5A5, "held word");
    cp(1'h1, 1'h1, 1'h1, REG_L2AUX, 32'h400);
    nrst = 1'h0;
    @(negedge ref_clk);
    chk("mid reset pin", 32'h0, {31'h0, ns_debug_read_dis_q});
    nrst = 1'h1;
    rdw(REG_DHOLD2, 32'h0, "reset held word");
    rdw(REG_L2AUX, 32'h0, "reset aux");
    rdw(4'hF, 32'h0, "unmapped");
    print_verdict();
  end
endmodule
